//--- dv/wcm_bus_model.sv
// far-end bus device model
`timescale 1ns/1ps
module wcm_bus_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic slow,
  input wire logic bus_tx_valid,
  input wire wcm_pkg::wcm_word_t bus_tx_word,
  output logic bus_tx_ready,
  output logic bus_rx_valid,
  output logic [15:0] bus_rx_data,
  input wire logic bus_rx_ready
);
  wcm_pkg::wcm_word_t got [$];
  logic [15:0] rxq [$];
  logic [2:0] cnt;
  always @(posedge clk_sys) begin
    if (!resetn) begin
      {bus_tx_ready, bus_rx_valid, cnt} <= 5'h00;
      bus_rx_data <= 16'hffff;
    end else begin
      cnt <= cnt + 3'h1;
      bus_tx_ready <= !slow || cnt == 3'h0; // slow takes one word in eight so the buffer fills
      if (bus_tx_valid && bus_tx_ready) got.push_back(bus_tx_word);
      if (bus_rx_valid && bus_rx_ready) begin
        bus_rx_valid <= 1'b0;
        bus_rx_data <= ~bus_rx_data; // released lines show no stale word
      end else if (!bus_rx_valid && rxq.size() > 0) begin
        bus_rx_valid <= 1'b1;
        bus_rx_data <= rxq.pop_front();
      end
    end
  end
endmodule : wcm_bus_model

//--- dv/wcm_move_residue_properties.sv
// port checker for the residue block
`timescale 1ns/1ps
module wcm_residue_chk (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire wcm_pkg::wcm_cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic move_done,
  input wire logic mem_rd_ready,
  input wire logic bus_tx_valid,
  input wire wcm_pkg::wcm_word_t bus_tx_word,
  input wire logic bus_tx_ready,
  input wire logic bus_rx_ready,
  input wire logic mem_wr_valid,
  input wire logic [7:0] mem_wr_data,
  input wire logic mem_wr_ready,
  input wire wcm_pkg::wcm_flags_t scsi_control_two_reg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  take_busy_a: assert property (cmd_valid && cmd_ready |=> !cmd_ready && !move_done)
    else $error("busy missing");
  done_pulse_a: assert property (move_done |-> cmd_ready ##1 !move_done)
    else $error("bad done");
  rd_pulse_a: assert property (mem_rd_ready |=> !mem_rd_ready)
    else $error("read ready held");
  rx_pulse_a: assert property (bus_rx_ready |=> !bus_rx_ready)
    else $error("rx ready held");
  tx_hold_a: assert property (bus_tx_valid && !bus_tx_ready |=>
    bus_tx_valid && $stable(bus_tx_word)) else $error("tx word moved");
  wr_hold_a: assert property (mem_wr_valid && !mem_wr_ready |=>
    mem_wr_valid && $stable(mem_wr_data)) else $error("write byte moved");
  rhold_set_a: assert property ($rose(scsi_control_two_reg.recv_hold) |->
    $past(mem_wr_valid) && $past(mem_wr_ready)) else $error("hold without write");
  shold_end_a: assert property ($rose(scsi_control_two_reg.send_hold) |-> move_done)
    else $error("send hold outside move end");
  rhold_end_a: assert property ($rose(scsi_control_two_reg.recv_hold) |-> move_done)
    else $error("receive hold outside move end");
  narrow_clr_a: assert property (cmd_valid && cmd_ready && !cmd.wide |->
    ##[1:3] scsi_control_two_reg == wcm_pkg::FLAGS_RST) else $error("narrow kept flag");
  cover property ($rose(scsi_control_two_reg.send_hold));
  cover property ($rose(scsi_control_two_reg.recv_hold));
  cover property (bus_tx_valid && bus_tx_ready && bus_tx_word.single);
endmodule : wcm_residue_chk

bind wcm_move_residue wcm_residue_chk u_chk (.clk_sys, .resetn, .cmd_valid, .cmd, .cmd_ready,
  .move_done, .mem_rd_ready, .bus_tx_valid, .bus_tx_word, .bus_tx_ready, .bus_rx_ready,
  .mem_wr_valid, .mem_wr_data, .mem_wr_ready, .scsi_control_two_reg);

//--- dv/wcm_move_residue_tb.sv
// bench for the wide move residue block
`timescale 1ns/1ps
module wcm_move_residue_tb;
  logic clk_sys, resetn, cmd_valid, cmd_ready, move_done, slow, mem_rd_valid, mem_rd_ready;
  logic bus_tx_valid, bus_tx_ready, bus_rx_valid, bus_rx_ready, mem_wr_valid, mem_wr_ready;
  logic [15:0] bus_rx_data;
  logic [7:0] mem_wr_data, src [0:15], wrq [$];
  logic [3:0] rp;
  wcm_pkg::wcm_cmd_t cmd;
  wcm_pkg::wcm_word_t bus_tx_word;
  wcm_pkg::wcm_flags_t flag_clear, scsi_control_two_reg;
  int mismatches = 0, n_tests = 0;
  wcm_move_residue u_dut (.clk_sys, .resetn, .cmd_valid, .cmd, .cmd_ready, .move_done,
    .mem_rd_valid, .mem_rd_data(src[rp]), .mem_rd_ready, .bus_tx_valid, .bus_tx_word,
    .bus_tx_ready, .bus_rx_valid, .bus_rx_data, .bus_rx_ready, .mem_wr_valid, .mem_wr_data,
    .mem_wr_ready, .flag_clear, .scsi_control_two_reg);
  wcm_bus_model u_bus (.clk_sys, .resetn, .slow, .bus_tx_valid, .bus_tx_word, .bus_tx_ready,
    .bus_rx_valid, .bus_rx_data, .bus_rx_ready);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // memory stalls writes every other cycle
  always @(posedge clk_sys) begin
    if (!resetn) begin
      mem_wr_ready <= 1'b0;
      rp <= 4'h0;
    end else begin
      mem_wr_ready <= ~mem_wr_ready;
      if (mem_rd_valid && mem_rd_ready) rp <= rp + 4'h1;
      if (mem_wr_valid && mem_wr_ready) wrq.push_back(mem_wr_data);
    end
  end
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cf(input logic [1:0] v);
    chk({15'h0000, scsi_control_two_reg}, {15'h0000, v});
  endtask : cf
  // f is initiator, data_out, chained, wide, sync
  task automatic go(input logic [4:0] f, input logic [15:0] n);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd <= {f, n};
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    for (int k = 0; k < 500 && move_done !== 1'b1; k++) @(posedge clk_sys);
    chk({16'h0000, move_done}, 17'h0_0001);
  endtask : go
  task automatic clr(input logic [1:0] v);
    @(posedge clk_sys);
    flag_clear <= v;
    @(posedge clk_sys);
    flag_clear <= 2'h0;
    @(posedge clk_sys);
  endtask : clr
  task automatic wtx(input int n);
    for (int k = 0; k < 200 && u_bus.got.size() < n; k++) @(posedge clk_sys);
  endtask : wtx
  task automatic t_send;
    logic [16:0] e [7] = '{17'h0_0200, 17'h0_0604, 17'h0_0a08, 17'h0_0e0c, 17'h0_1210,
      17'h0_1614, 17'h0_0019};
    slow <= 1'b1;
    go(5'h1f, 16'h0005);
    cf(2'h2);
    go(5'h02, 16'h0005);
    cf(2'h0);
    go(5'h1a, 16'h0003);
    cf(2'h0);
    wtx(7);
    chk(17'(u_bus.got.size()), 17'h0_0007);
    for (int i = 0; i < 7; i++)
      chk(u_bus.got[i] & (i < 6 ? 17'h1_ffff : 17'h0_01ff), e[i]);
    slow <= 1'b0;
    $display("t_send end");
  endtask : t_send
  task automatic t_recv;
    logic [7:0] e [5] = '{8'h22, 8'h11, 8'h44, 8'h33, 8'h66};
    wrq.delete();
    u_bus.rxq = '{16'h1122, 16'h3344, 16'h5566};
    go(5'h16, 16'h0003);
    cf(2'h1);
    go(5'h0a, 16'h0002);
    cf(2'h0);
    chk(17'(wrq.size()), 17'h0_0005);
    for (int i = 0; i < 5; i++)
      chk({9'h000, wrq[i]}, {9'h000, e[i]});
    $display("t_recv end");
  endtask : t_recv
  task automatic t_flags;
    u_bus.got.delete();
    wrq.delete();
    u_bus.rxq = '{16'h7788, 16'haabb, 16'hccdd, 16'h99ee};
    go(5'h1e, 16'h0001);
    go(5'h1a, 16'h0001);
    cf(2'h0);
    go(5'h1e, 16'h0001);
    clr(2'h2);
    cf(2'h0);
    go(5'h1e, 16'h0001);
    go(5'h16, 16'h0002);
    cf(2'h0);
    go(5'h16, 16'h0001);
    clr(2'h1);
    cf(2'h0);
    go(5'h16, 16'h0001);
    go(5'h18, 16'h0001);
    cf(2'h0);
    go(5'h1e, 16'h0001);
    cf(2'h2);
    go(5'h10, 16'h0001);
    cf(2'h0);
    wtx(2);
    chk(u_bus.got[0], 17'h0_1c1a);
    chk(u_bus.got[1] & 17'h0_01ff, 17'h0_0003);
    chk({9'h000, wrq[3]}, 17'h0_00dd);
    chk({9'h000, wrq[4]}, 17'h0_00ee);
    $display("t_flags end");
  endtask : t_flags
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  initial begin
    {resetn, cmd_valid, mem_rd_valid, slow} = 4'h0;
    cmd = 22'h00_0000;
    flag_clear = 2'h0;
    for (int i = 0; i < 16; i++) src[i] = 8'(i);
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    mem_rd_valid <= 1'b1;
    t_send();
    t_recv();
    t_flags();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    test_done();
  end
endmodule : wcm_move_residue_tb

//--- verilog/wcm_move_residue.sv
// odd-byte residue handling for wide chained data moves
`timescale 1ns/1ps
module wcm_move_residue (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire wcm_pkg::wcm_cmd_t cmd,
  output logic cmd_ready,
  output logic move_done,
  input wire logic mem_rd_valid,
  input wire logic [7:0] mem_rd_data,
  output logic mem_rd_ready,
  output logic bus_tx_valid,
  output wcm_pkg::wcm_word_t bus_tx_word,
  input wire logic bus_tx_ready,
  input wire logic bus_rx_valid,
  input wire logic [15:0] bus_rx_data,
  output logic bus_rx_ready,
  output logic mem_wr_valid,
  output logic [7:0] mem_wr_data,
  input wire logic mem_wr_ready,
  input wire wcm_pkg::wcm_flags_t flag_clear,
  output wcm_pkg::wcm_flags_t scsi_control_two_reg
);
  wcm_pkg::wcm_state_t state;
  wcm_pkg::wcm_cmd_t cur;
  logic [wcm_pkg::COUNT_W-1:0] cnt;
  logic [7:0] lo_byte;
  logic have_lo;
  logic from_hold;
  logic [7:0] scsi_output_latch;
  logic [7:0] chain_hold;
  logic hold_sync;
  logic [7:0] wide_residue_reg;
  logic [15:0] rx_word;
  logic rx_high;
  logic start;
  logic start_send;
  logic take_tx;
  logic take_rx;
  logic mem_done;
  logic buf_wr;
  wcm_pkg::wcm_word_t buf_din;
  logic buf_ready;
  logic set_send;
  logic clr_send;
  logic set_recv;
  logic clr_recv;
  logic send_end_hold;

  assign start = cmd_valid && cmd_ready;
  assign start_send = cmd.initiator == cmd.data_out;
  assign take_tx = mem_rd_valid && mem_rd_ready;
  assign take_rx = bus_rx_valid && bus_rx_ready;
  assign mem_done = mem_wr_valid && mem_wr_ready;
  // ordinary moves always flush, only chained ones may hold a byte
  assign send_end_hold = state == wcm_pkg::ST_SEND && cnt == wcm_pkg::COUNT_ZERO
    && have_lo && cur.chained;

  // word assembly toward the buffer
  always_comb begin
    buf_wr = 1'b0;
    buf_din = '0;
    if (state == wcm_pkg::ST_SEND && take_tx) begin
      if (!cur.wide) begin
        buf_wr = 1'b1;
        buf_din = {8'h00, mem_rd_data, 1'b1};
      end else if (have_lo) begin
        buf_wr = 1'b1;
        buf_din = {mem_rd_data, lo_byte, 1'b0};
      end
    end else if (state == wcm_pkg::ST_SEND_END && buf_ready) begin
      buf_wr = 1'b1;
      buf_din = {8'h00, lo_byte, 1'b1};
    end
  end

  // hold flag set and clear terms
  always_comb begin
    set_send = send_end_hold;
    set_recv = state == wcm_pkg::ST_RX_BYTE && mem_done && !rx_high && cur.wide
      && cur.chained && cnt == wcm_pkg::COUNT_ONE;
    clr_send = flag_clear.send_hold;
    clr_recv = flag_clear.recv_hold;
    if (start && (!start_send || !cmd.wide)) begin
      clr_send = 1'b1;
    end
    if (start && (start_send || !cmd.wide
        || cmd.count != wcm_pkg::COUNT_ZERO)) begin
      clr_recv = 1'b1;
    end
    // cleared on entry to the buffer, even if the bus still stalls on it
    if (buf_wr && from_hold) begin
      clr_send = 1'b1;
    end
  end

  // hardware set wins over any clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      scsi_control_two_reg <= wcm_pkg::FLAGS_RST;
    end else begin
      if (set_send) begin
        scsi_control_two_reg.send_hold <= 1'b1;
      end else if (clr_send) begin
        scsi_control_two_reg.send_hold <= 1'b0;
      end
      if (set_recv) begin
        scsi_control_two_reg.recv_hold <= 1'b1;
      end else if (clr_recv) begin
        scsi_control_two_reg.recv_hold <= 1'b0;
      end
    end
  end

  // held bytes, kept apart for async and sync sends
  // the source of a held byte follows the move that held it, not the next
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      scsi_output_latch <= wcm_pkg::BYTE_RST;
      chain_hold <= wcm_pkg::BYTE_RST;
      hold_sync <= 1'b0;
      wide_residue_reg <= wcm_pkg::BYTE_RST;
    end else begin
      if (send_end_hold) begin
        hold_sync <= cur.sync;
        if (cur.sync) begin
          chain_hold <= lo_byte;
        end else begin
          scsi_output_latch <= lo_byte;
        end
      end
      if (set_recv) begin
        wide_residue_reg <= rx_word[15:8];
      end
    end
  end

  // move sequencing, counting memory-side bytes
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state <= wcm_pkg::ST_IDLE;
      cur <= '0;
      cnt <= wcm_pkg::COUNT_ZERO;
      lo_byte <= wcm_pkg::BYTE_RST;
      have_lo <= 1'b0;
      from_hold <= 1'b0;
      rx_word <= wcm_pkg::WORD_RST;
      rx_high <= 1'b0;
      cmd_ready <= 1'b1;
      move_done <= 1'b0;
      mem_rd_ready <= 1'b0;
      bus_rx_ready <= 1'b0;
      mem_wr_valid <= 1'b0;
      mem_wr_data <= wcm_pkg::BYTE_RST;
    end else begin
      move_done <= 1'b0;
      if (mem_done) begin
        mem_wr_valid <= 1'b0;
      end
      unique case (state)
        wcm_pkg::ST_IDLE: begin
          if (start) begin
            cur <= cmd;
            cnt <= cmd.count;
            cmd_ready <= 1'b0;
            have_lo <= 1'b0;
            from_hold <= 1'b0;
            if (start_send) begin
              state <= wcm_pkg::ST_SEND;
              if (cmd.wide && scsi_control_two_reg.send_hold) begin
                have_lo <= 1'b1;
                from_hold <= 1'b1;
                lo_byte <= hold_sync ? chain_hold : scsi_output_latch;
              end
            // an empty wide receive leaves the residue and its flag alone
            end else if (cmd.wide && scsi_control_two_reg.recv_hold
                && cmd.count != wcm_pkg::COUNT_ZERO) begin
              state <= wcm_pkg::ST_RX_RES;
              mem_wr_valid <= 1'b1;
              mem_wr_data <= wide_residue_reg;
            end else begin
              state <= wcm_pkg::ST_RX_GET;
            end
          end
        end
        wcm_pkg::ST_SEND: begin
          // one byte every other cycle keeps ready a plain flop
          mem_rd_ready <= !take_tx && !mem_rd_ready && buf_ready
            && cnt != wcm_pkg::COUNT_ZERO;
          if (take_tx) begin
            cnt <= cnt - wcm_pkg::COUNT_ONE;
            from_hold <= 1'b0;
            if (cur.wide) begin
              have_lo <= !have_lo;
              lo_byte <= mem_rd_data;
            end
          end else if (cnt == wcm_pkg::COUNT_ZERO && !mem_rd_ready) begin
            if (have_lo && !cur.chained) begin
              state <= wcm_pkg::ST_SEND_END;
            end else begin
              state <= wcm_pkg::ST_IDLE;
              cmd_ready <= 1'b1;
              move_done <= 1'b1;
            end
          end
        end
        wcm_pkg::ST_SEND_END: begin
          // waits for room, the lone byte must not be dropped
          if (buf_ready) begin
            have_lo <= 1'b0;
            state <= wcm_pkg::ST_IDLE;
            cmd_ready <= 1'b1;
            move_done <= 1'b1;
          end
        end
        wcm_pkg::ST_RX_RES: begin
          // the residue byte is one of this move's counted bytes
          if (mem_done) begin
            cnt <= cnt - wcm_pkg::COUNT_ONE;
            if (cnt == wcm_pkg::COUNT_ONE) begin
              state <= wcm_pkg::ST_IDLE;
              cmd_ready <= 1'b1;
              move_done <= 1'b1;
            end else begin
              state <= wcm_pkg::ST_RX_GET;
            end
          end
        end
        wcm_pkg::ST_RX_GET: begin
          // one word in flight, so rx_word is never overwritten early
          bus_rx_ready <= !take_rx && !bus_rx_ready
            && cnt != wcm_pkg::COUNT_ZERO;
          if (take_rx) begin
            rx_word <= bus_rx_data;
            rx_high <= 1'b0;
            mem_wr_valid <= 1'b1;
            mem_wr_data <= bus_rx_data[7:0];
            state <= wcm_pkg::ST_RX_BYTE;
          end else if (cnt == wcm_pkg::COUNT_ZERO && !bus_rx_ready) begin
            state <= wcm_pkg::ST_IDLE;
            cmd_ready <= 1'b1;
            move_done <= 1'b1;
          end
        end
        wcm_pkg::ST_RX_BYTE: begin
          if (mem_done) begin
            cnt <= cnt - wcm_pkg::COUNT_ONE;
            if (cnt == wcm_pkg::COUNT_ONE) begin
              // an ordinary move drops the spare high byte
              state <= wcm_pkg::ST_IDLE;
              cmd_ready <= 1'b1;
              move_done <= 1'b1;
            end else if (cur.wide && !rx_high) begin
              rx_high <= 1'b1;
              mem_wr_valid <= 1'b1;
              mem_wr_data <= rx_word[15:8];
            end else begin
              state <= wcm_pkg::ST_RX_GET;
            end
          end
        end
        default: begin
          state <= wcm_pkg::ST_IDLE;
          cmd_ready <= 1'b1;
        end
      endcase
    end
  end

  // a stalled bus receiver fills this and then holds memory reads off
  wcm_skid_buf #(
    .W(wcm_pkg::WORD_W)
  ) u_tx_buf (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .in_valid(buf_wr),
    .in_data(buf_din),
    .in_ready(buf_ready),
    .out_valid(bus_tx_valid),
    .out_data(bus_tx_word),
    .out_ready(bus_tx_ready)
  );
endmodule : wcm_move_residue

//--- verilog/wcm_pkg.sv
// shared types and constants for the wide chained move residue block
package wcm_pkg;
  localparam int COUNT_W = 16;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // one move instruction as handed over by the script engine
  typedef struct packed {
    logic initiator;
    logic data_out;
    logic chained;
    logic wide;
    logic sync;
    logic [COUNT_W-1:0] count;
  } wcm_cmd_t;

  // word toward the bus; single marks a lone low-order byte
  typedef struct packed {
    logic [15:0] data;
    logic single;
  } wcm_word_t;

  localparam int WORD_W = 17;

  // the two hold flags of the scsi control two register
  typedef struct packed {
    logic send_hold;
    logic recv_hold;
  } wcm_flags_t;

  localparam wcm_flags_t FLAGS_RST = 2'b00;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_SEND = 6'b000010,
    ST_SEND_END = 6'b000100,
    ST_RX_RES = 6'b001000,
    ST_RX_GET = 6'b010000,
    ST_RX_BYTE = 6'b100000
  } wcm_state_t;
endpackage : wcm_pkg

//--- verilog/wcm_skid_buf.sv
// two-entry buffer with registered outputs and registered ready
`timescale 1ns/1ps
module wcm_skid_buf #(
  parameter int W = 17
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  logic [W-1:0] tail;
  logic tail_valid;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // ready only depends on the spare slot, so it never waits on out_ready
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      out_valid <= 1'b0;
      out_data <= '0;
      tail <= '0;
      tail_valid <= 1'b0;
      in_ready <= 1'b1;
    end else begin
      unique case ({push, pop})
        2'b10: begin
          if (!out_valid) begin
            out_data <= in_data;
            out_valid <= 1'b1;
          end else begin
            tail <= in_data;
            tail_valid <= 1'b1;
            in_ready <= 1'b0;
          end
        end
        2'b01: begin
          if (tail_valid) begin
            out_data <= tail;
            tail_valid <= 1'b0;
            in_ready <= 1'b1;
          end else begin
            out_valid <= 1'b0;
          end
        end
        2'b11: begin
          out_data <= in_data;
        end
        default: begin
        end
      endcase
    end
  end
endmodule : wcm_skid_buf
